// *** tctl_top.sv ***
// Operation
// - holds an 18-bit compare value and an 8-bit gate width setting
// - run field 00 stops, clears count and overflow; 10 starts counting
// - writing low or mid compare byte blocks matching until top byte written
// - reading the compare address returns the live counter value
// - top compare byte bits 7 to 2 read zero, ignore ones
// - timer mode counts up, on match raises interrupt, clears, resumes
//
// Added by the designer: the AXI4-Lite slave port.
`include "tctl_map.svh"
`default_nettype none
module tctl_top
  import tctl_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        lf_tick,
  input  wire logic        external_count_input,
  output logic [7:0]       gate_width_q,
  output logic             match_interrupt_q,
  output logic             irq_q
);
  // ==========================================================
  // state
  logic [`TCTL_CNT_W-1:0] count_q, count_d;
  logic [`TCTL_CNT_W-1:0] cmp_q, cmp_d;
  logic                   cmp_hold_q, cmp_hold_d;
  logic                   ovf_q, ovf_d;
  logic [7:0]             ctrl1_q, ctrl1_d;
  logic                   lsps_q, lsps_d;
  logic [1:0]             stat_q, stat_d;
  logic [1:0]             en_q, en_d;
  logic [7:0]             gate_width_d;
  logic                   match_interrupt_d;
  logic                   irq_d;
  logic [`TCTL_PRE_W-1:0] pre_q, pre_d;
  logic [15:0]            lpre_q, lpre_d;
  logic [7:0]             aw_addr_q, aw_addr_d;
  logic                   aw_got_q, aw_got_d;
  logic [7:0]             w_data_q, w_data_d;
  logic                   w_en_q, w_en_d;
  logic                   w_got_q, w_got_d;
  logic                   awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0]             bresp_d, rresp_d;
  logic [31:0]            rdata_d;
  logic                   ext_level, ext_rise;

  tctl_sync u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pin_in  (external_count_input),
    .level_q (ext_level),
    .rise_q  (ext_rise)
  );

  // ==========================================================
  // count enable selection
  logic       tick;
  logic       hit;
  logic       wrap;
  tctl_run_e  run;
  tctl_mode_e mode;
  tctl_src_e  src;
  logic       wr_go;
  logic       rd_go;
  logic       lt15, lt5, lt3;

  always_comb begin
    run   = tctl_run_e'(ctrl1_q[`TCTL_RUN_HI:`TCTL_RUN_LO]);
    mode  = tctl_mode_e'(ctrl1_q[`TCTL_MODE_HI:`TCTL_MODE_LO]);
    src   = tctl_src_e'(ctrl1_q[`TCTL_SRC_HI:`TCTL_SRC_LO]);
    pre_d = pre_q + 1'b1;
    lpre_d = lpre_q;
    if (lf_tick) begin
      lpre_d = lpre_q + 1'b1;
    end
    // low-speed taps advance on the low-frequency tick only
    lt15 = lf_tick & (&lpre_q[14:0]);
    lt5  = lf_tick & (&lpre_q[4:0]);
    lt3  = lf_tick & (&lpre_q[2:0]);
    case (src)
      TCTL_SRC_FC:  tick = 1'b1;
      TCTL_SRC_T1:  tick = lsps_q ? lt15 : (&pre_q[22:0]);
      TCTL_SRC_T2:  tick = lsps_q ? lt5 : (&pre_q[12:0]);
      TCTL_SRC_T3:  tick = lsps_q ? lt3 : (&pre_q[10:0]);
      TCTL_SRC_T4:  tick = &pre_q[6:0];
      TCTL_SRC_T5:  tick = &pre_q[4:0];
      TCTL_SRC_T6:  tick = &pre_q[2:0];
      TCTL_SRC_EXT: tick = ext_rise;
      default:      tick = 1'b0;
    endcase
    // pulse width mode counts only while the input is high
    if (mode == TCTL_MODE_PWM) begin
      tick = tick & ext_level;
    end else if (mode != TCTL_MODE_TIMER) begin
      tick = 1'b0;
    end
  end

  // ==========================================================
  // bus, registers and counter
  always_comb begin
    count_d      = count_q;
    cmp_d        = cmp_q;
    cmp_hold_d   = cmp_hold_q;
    ovf_d        = ovf_q;
    ctrl1_d      = ctrl1_q;
    lsps_d       = lsps_q;
    stat_d       = stat_q;
    en_d         = en_q;
    gate_width_d = gate_width_q;
    aw_addr_d    = aw_addr_q;
    aw_got_d     = aw_got_q;
    w_data_d     = w_data_q;
    w_en_d       = w_en_q;
    w_got_d      = w_got_q;
    bvalid_d     = s_axi_bvalid;
    bresp_d      = s_axi_bresp;
    rvalid_d     = s_axi_rvalid;
    rresp_d      = s_axi_rresp;
    rdata_d      = s_axi_rdata;
    hit          = 1'b0;
    wrap         = 1'b0;
    match_interrupt_d = 1'b0;

    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_d = s_axi_awaddr;
      aw_got_d  = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data_d = s_axi_wdata[7:0];
      w_en_d   = s_axi_wstrb[0];
      w_got_d  = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end

    // counter runs first so a run-stop write in the same cycle wins
    if (run == TCTL_RUN_START && tick) begin
      // match clears and resumes; suppressed while held
      if (!cmp_hold_q && count_q == cmp_q) begin
        hit     = 1'b1;
        count_d = '0;
      end else begin
        count_d = count_q + 1'b1;
        if (&count_q) begin
          ovf_d = 1'b1;
          wrap  = 1'b1;
        end
      end
    end
    match_interrupt_d = hit;

    wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
    if (wr_go) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = `TCTL_RESP_OK;
      case (aw_addr_q)
        `TCTL_ADDR_CMP_LO: if (w_en_q) begin
          // low byte write holds off matching
          cmp_d[7:0] = w_data_q;
          cmp_hold_d = 1'b1;
        end
        `TCTL_ADDR_CMP_MID: if (w_en_q) begin
          cmp_d[15:8] = w_data_q;
          cmp_hold_d  = 1'b1;
        end
        `TCTL_ADDR_CMP_TOP: if (w_en_q) begin
          cmp_d[`TCTL_CNT_W-1:16] = w_data_q[`TCTL_TOP_BITS-1:0];
          cmp_hold_d = 1'b0;
        end
        `TCTL_ADDR_GATE: if (w_en_q) begin
          gate_width_d = w_data_q;
        end
        `TCTL_ADDR_CTRL1: if (w_en_q) begin
          ctrl1_d = w_data_q;
          // writing zero clears the flag; a wrap in the same cycle wins unless the write also stops the counter
          if (!w_data_q[`TCTL_OVF_BIT] && !wrap) begin
            ovf_d = 1'b0;
          end
        end
        `TCTL_ADDR_CFG: if (w_en_q) begin
          lsps_d = w_data_q[`TCTL_CFG_LSPS_BIT];
        end
        `TCTL_ADDR_CLR: if (w_en_q) begin
          stat_d = stat_q & ~w_data_q[1:0];
        end
        `TCTL_ADDR_EN: if (w_en_q) begin
          en_d = w_data_q[1:0];
        end
        `TCTL_ADDR_STAT: bresp_d = `TCTL_RESP_OK;
        default: bresp_d = `TCTL_RESP_ERR;
      endcase
    end

    if (tctl_run_e'(ctrl1_d[`TCTL_RUN_HI:`TCTL_RUN_LO]) == TCTL_RUN_STOP) begin
      count_d = '0;
      ovf_d   = 1'b0;
    end

    // events set status, set wins over a same-cycle clear
    if (hit) begin
      stat_d[`TCTL_ST_MATCH] = 1'b1;
    end
    if (wrap) begin
      stat_d[`TCTL_ST_OVF] = 1'b1;
    end

    rd_go = s_axi_arvalid && s_axi_arready;
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = `TCTL_RESP_OK;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        // compare address reads live count; upper bits zero
        `TCTL_ADDR_CMP_LO:  rdata_d[7:0] = count_q[7:0];
        `TCTL_ADDR_CMP_MID: rdata_d[7:0] = count_q[15:8];
        `TCTL_ADDR_CMP_TOP: rdata_d[`TCTL_TOP_BITS-1:0] = count_q[`TCTL_CNT_W-1:16];
        `TCTL_ADDR_GATE:    rdata_d[7:0] = gate_width_q;
        `TCTL_ADDR_CTRL1:   rdata_d[7:0] = {ovf_q, ctrl1_q[6:0]};
        `TCTL_ADDR_CFG:     rdata_d[`TCTL_CFG_LSPS_BIT] = lsps_q;
        `TCTL_ADDR_STAT:    rdata_d[1:0] = stat_q;
        `TCTL_ADDR_CLR:     rdata_d = 32'h0000_0000;
        `TCTL_ADDR_EN:      rdata_d[1:0] = en_q;
        default:            rresp_d = `TCTL_RESP_ERR;
      endcase
    end

    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
    arready_d = !rvalid_d;
    irq_d     = |(stat_d & en_d);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_q           <= '0;
      cmp_q             <= '0;
      cmp_hold_q        <= 1'b0;
      ovf_q             <= 1'b0;
      ctrl1_q           <= `TCTL_CTRL1_RST;
      lsps_q            <= 1'b0;
      stat_q            <= 2'h0;
      en_q              <= 2'h0;
      gate_width_q      <= 8'h00;
      match_interrupt_q <= 1'b0;
      irq_q             <= 1'b0;
      pre_q             <= '0;
      lpre_q            <= 16'h0000;
      aw_addr_q         <= 8'h00;
      aw_got_q          <= 1'b0;
      w_data_q          <= 8'h00;
      w_en_q            <= 1'b0;
      w_got_q           <= 1'b0;
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= 2'h0;
      s_axi_arready     <= 1'b0;
      s_axi_rvalid      <= 1'b0;
      s_axi_rresp       <= 2'h0;
      s_axi_rdata       <= 32'h0000_0000;
    end else begin
      count_q           <= count_d;
      cmp_q             <= cmp_d;
      cmp_hold_q        <= cmp_hold_d;
      ovf_q             <= ovf_d;
      ctrl1_q           <= ctrl1_d;
      lsps_q            <= lsps_d;
      stat_q            <= stat_d;
      en_q              <= en_d;
      gate_width_q      <= gate_width_d;
      match_interrupt_q <= match_interrupt_d;
      irq_q             <= irq_d;
      pre_q             <= pre_d;
      lpre_q            <= lpre_d;
      aw_addr_q         <= aw_addr_d;
      aw_got_q          <= aw_got_d;
      w_data_q          <= w_data_d;
      w_en_q            <= w_en_d;
      w_got_q           <= w_got_d;
      s_axi_awready     <= awready_d;
      s_axi_wready      <= wready_d;
      s_axi_bvalid      <= bvalid_d;
      s_axi_bresp       <= bresp_d;
      s_axi_arready     <= arready_d;
      s_axi_rvalid      <= rvalid_d;
      s_axi_rresp       <= rresp_d;
      s_axi_rdata       <= rdata_d;
    end
  end
endmodule : tctl_top
`default_nettype wire

// *** tctl_map.svh ***
`ifndef TCTL_MAP_SVH
`define TCTL_MAP_SVH
// ==========================================================
// register byte addresses
`define TCTL_ADDR_CMP_LO   8'h00
`define TCTL_ADDR_CMP_MID  8'h04
`define TCTL_ADDR_CMP_TOP  8'h08
`define TCTL_ADDR_GATE     8'h0C
`define TCTL_ADDR_CTRL1    8'h14
`define TCTL_ADDR_CFG      8'h18
`define TCTL_ADDR_STAT     8'h1C
`define TCTL_ADDR_CLR      8'h20
`define TCTL_ADDR_EN       8'h24
// ==========================================================
// control one fields
`define TCTL_OVF_BIT       7
`define TCTL_RUN_HI        6
`define TCTL_RUN_LO        5
`define TCTL_SRC_HI        4
`define TCTL_SRC_LO        2
`define TCTL_MODE_HI       1
`define TCTL_MODE_LO       0
`define TCTL_CTRL1_RST     8'h00
// ==========================================================
// other fields and constants
`define TCTL_CFG_LSPS_BIT  0
`define TCTL_ST_MATCH      0
`define TCTL_ST_OVF        1
`define TCTL_TOP_BITS      2
`define TCTL_CNT_W         18
`define TCTL_PRE_W         23
`define TCTL_RESP_OK       2'h0
`define TCTL_RESP_ERR      2'h2
`endif

// *** tctl_pkg.sv ***
`default_nettype none
package tctl_pkg;
  typedef enum logic [1:0] {
    TCTL_RUN_STOP  = 2'h0,
    TCTL_RUN_RSV1  = 2'h1,
    TCTL_RUN_START = 2'h2,
    TCTL_RUN_RSV3  = 2'h3
  } tctl_run_e;
  typedef enum logic [1:0] {
    TCTL_MODE_TIMER = 2'h0,
    TCTL_MODE_RSV   = 2'h1,
    TCTL_MODE_PWM   = 2'h2,
    TCTL_MODE_RSV3  = 2'h3
  } tctl_mode_e;
  typedef enum logic [2:0] {
    TCTL_SRC_FC   = 3'h0,
    TCTL_SRC_T1   = 3'h1,
    TCTL_SRC_T2   = 3'h2,
    TCTL_SRC_T3   = 3'h3,
    TCTL_SRC_T4   = 3'h4,
    TCTL_SRC_T5   = 3'h5,
    TCTL_SRC_T6   = 3'h6,
    TCTL_SRC_EXT  = 3'h7
  } tctl_src_e;
endpackage : tctl_pkg
`default_nettype wire

// *** tctl_sync.sv ***
`default_nettype none
module tctl_sync (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_q,
  output logic      rise_q
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       level_d;
  logic       rise_d;

  // ==========================================================
  // three stages, change accepted when stages two and three agree
  always_comb begin
    sh_d    = {sh_q[1:0], pin_in};
    level_d = level_q;
    rise_d  = 1'b0;
    if (sh_q[1] == sh_q[2]) begin
      level_d = sh_q[2];
      rise_d  = sh_q[2] & ~level_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sh_q    <= 3'h0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      sh_q    <= sh_d;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end
endmodule : tctl_sync
`default_nettype wire

// *** tctl_top_sva.sv ***
`include "tctl_map.svh"
`default_nettype none
module tctl_top_sva (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  gate_width_q,
  input wire logic        match_interrupt_q
);
  logic [7:0] ra_q;
  logic [7:0] ra_d;
  // ==========================================================
  // read address in flight, to judge the data it returns
  always_comb ra_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
  always_ff @(posedge sys_clk) ra_q <= sys_rst ? 8'h00 : ra_d;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // properties
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_two: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_top_zero: assert property (
    s_axi_rvalid && ra_q == `TCTL_ADDR_CMP_TOP |-> s_axi_rdata[7:2] == 6'h0)
    else $error("top compare byte upper bits set");
  a_hole_error: assert property (s_axi_rvalid && ra_q == 8'h10 |->
    s_axi_rresp == `TCTL_RESP_ERR) else $error("unmapped read not refused");
  a_gate_write: assert property ($changed(gate_width_q) |-> $rose(s_axi_bvalid))
    else $error("gate width changed without write");
  a_match_pulse: assert property (match_interrupt_q |=> !match_interrupt_q)
    else $error("match pulse too long");
endmodule : tctl_top_sva
bind tctl_top tctl_top_sva u_sva (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .gate_width_q(gate_width_q),
  .match_interrupt_q(match_interrupt_q));
`default_nettype wire

// *** tctl_top_bench.sv ***
`include "tctl_map.svh"
`default_nettype none
module tctl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, lf_tick, ext, mi, irq;
  logic [7:0]  awaddr, araddr, gw, c, v;
  logic [2:0]  s;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, num_checks, cyc, seed, nm, t, n;
  tctl_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lf_tick(lf_tick), .external_count_input(ext),
    .gate_width_q(gw), .match_interrupt_q(mi), .irq_q(irq));
  // ==========================================================
  // checking and closing
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm_s, e, g);
    end
  endtask : chk
  // ==========================================================
  // bus master
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    bit ad;
    bit wd;
    int k;
    ad = 0;
    wd = 0;
    k = $random(seed) & 3;
    awaddr <= a;
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end while (!(ad && wd));
    // late bready lets a waiting response stand a few cycles
    repeat (k) @(posedge sys_clk);
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // one idle edge so a following call never reassigns in this step
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    k = $random(seed) & 3;
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (k) @(posedge sys_clk);
    rready <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  function automatic int period_of(input logic [7:0] cmp, input logic [2:0] src);
    // source 6 ticks once per eight clocks, source 0 on every clock
    return (cmp + 1) * ((src == 3'h6) ? 8 : 1);
  endfunction : period_of
  function automatic logic [7:0] ctl(input logic [1:0] run, input logic [2:0] src);
    return {1'b0, run, src, 2'b00};
  endfunction : ctl
  // ==========================================================
  // clock, watchdog, match counting, slow tick
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (mi === 1'b1) nm++;
    lf_tick <= ($random(seed) % 5 == 0);
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h64a4;
    {sys_rst, awvalid, wvalid, bready, arvalid, rready, ext} <= 7'h40;
    {awaddr, araddr, wdata} <= 48'h0;
    wstrb <= 4'hF;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`TCTL_ADDR_CTRL1);
    chk("ctrl1_reset", 32'h0, d);
    v = $random(seed);
    wr(`TCTL_ADDR_GATE, v);
    rd(`TCTL_ADDR_GATE);
    chk("gate_rd", {24'h0, v}, d);
    chk("gate_pin", {24'h0, v}, {24'h0, gw});
    // a cleared byte strobe leaves the register alone
    wstrb <= 4'hE;
    wr(`TCTL_ADDR_GATE, ~v);
    wstrb <= 4'hF;
    rd(`TCTL_ADDR_GATE);
    chk("gate_keep", {24'h0, v}, d);
    wr(8'h10, 8'h5A);
    chk("wr_hole", `TCTL_RESP_ERR, r);
    rd(8'h10);
    chk("rd_hole", `TCTL_RESP_ERR, r);
    wr(`TCTL_ADDR_CMP_TOP, 8'hFF);
    rd(`TCTL_ADDR_CMP_TOP);
    chk("top_rd", 32'h0, d);
    // odd passes leave the interrupt masked; upper passes use the eight-clock tap
    for (int i = 0; i < 4; i++) begin
      c = 8'h02 + ($random(seed) & 8'h0F);
      s = i[1] ? 3'h6 : 3'h0;
      wr(`TCTL_ADDR_EN, i[0] ? 8'h00 : 8'h01);
      wr(`TCTL_ADDR_CTRL1, 8'h00);
      wr(`TCTL_ADDR_CMP_LO, c);
      wr(`TCTL_ADDR_CMP_MID, 8'h00);
      wr(`TCTL_ADDR_CMP_TOP, 8'h00);
      wr(`TCTL_ADDR_CTRL1, ctl(2'b10, s));
      rd(`TCTL_ADDR_CTRL1);
      chk("ctrl1_rd", {24'h0, ctl(2'b10, s)}, d);
      t = 0;
      do @(posedge sys_clk); while (mi !== 1'b1);
      do begin
        @(posedge sys_clk);
        t++;
      end while (mi !== 1'b1 && t < 200);
      chk("period", period_of(c, s), t);
      chk("irq", {31'h0, ~i[0]}, {31'h0, irq});
      wr(`TCTL_ADDR_CTRL1, 8'h00);
      rd(`TCTL_ADDR_STAT);
      chk("stat_match", 32'h1, d & 32'h1);
      rd(`TCTL_ADDR_CMP_LO);
      chk("stop_clear", 32'h0, d);
      wr(`TCTL_ADDR_CLR, 8'h03);
      rd(`TCTL_ADDR_STAT);
      chk("irq_clr", 32'h0, {d[30:0], irq});
    end
    // reserved run code must not count
    wr(`TCTL_ADDR_CTRL1, ctl(2'b01, 3'h0));
    repeat (10) @(posedge sys_clk);
    rd(`TCTL_ADDR_CMP_LO);
    chk("rsv_run", 32'h0, d);
    // low byte rewritten last: matching held while external edges count
    wr(`TCTL_ADDR_CTRL1, 8'h00);
    wr(`TCTL_ADDR_CMP_LO, 8'h02);
    wr(`TCTL_ADDR_CMP_MID, 8'h00);
    wr(`TCTL_ADDR_CMP_TOP, 8'h00);
    wr(`TCTL_ADDR_CMP_LO, 8'h02);
    // external input as count source in timer mode
    wr(`TCTL_ADDR_CTRL1, ctl(2'b10, 3'h7));
    nm = 0;
    n = 3 + ($random(seed) & 3);
    repeat (n) begin
      ext <= 1'b1;
      repeat (4) @(posedge sys_clk);
      ext <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    rd(`TCTL_ADDR_CMP_LO);
    chk("ext_count", n, d);
    chk("no_match", 32'h0, nm);
    report_and_stop();
  end
endmodule : tctl_top_bench
`default_nettype wire
